/* rtl/fileop_exec.sv */
// execution of complement, decrement and decrement-skip-if-zero
`timescale 1ns/1ps
`default_nettype none
module fileop_exec (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [13:0] insn,
  output logic [1:0] phase,
  output logic insn_taken,
  output logic [6:0] reg_addr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic [7:0] w_reg,
  output logic zero_flag,
  output logic skip_active,
  output logic unknown_op
);
  // ************************************************************
  // phase sequencing
  // ************************************************************
  fileop_pkg::phase_t ph;
  logic cycle_end;

  phase_counter phase_counter_inst (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .phase(ph),
    .cycle_end(cycle_end)
  );

  // ************************************************************
  // decode
  // ************************************************************
  logic [13:0] ir_q;
  logic [7:0] data_q;
  logic [7:0] result_q;
  logic [7:0] w_q;
  logic z_q;
  logic skip_q;
  logic wr_q;
  logic [7:0] wdata_q;

  wire [5:0] opc = ir_q[fileop_pkg::OPC_HI:fileop_pkg::OPC_LO];
  wire [6:0] addr = ir_q[fileop_pkg::ADDR_W-1:0]; // RULE6
  wire dest_f = ir_q[fileop_pkg::DEST_BIT]; // RULE6
  wire is_comp = (opc == fileop_pkg::OPC_COMPLEMENT);
  wire is_dec = (opc == fileop_pkg::OPC_DECREMENT);
  wire is_dsz = (opc == fileop_pkg::OPC_DEC_SKIP);
  wire known = is_comp | is_dec | is_dsz;
  wire exec_ok = known & ~skip_q;

  // ************************************************************
  // process
  // ************************************************************
  wire [7:0] comp_val = ~data_q; // RULE1
  wire [7:0] dec_val = data_q - fileop_pkg::ONE; // RULE2 RULE3
  wire [7:0] proc_val = is_comp ? comp_val : dec_val;
  wire res_zero = (result_q == fileop_pkg::ZERO);
  wire upd_z = exec_ok & (is_comp | is_dec); // RULE1 RULE2
  wire set_skip = exec_ok & is_dsz & res_zero; // RULE4
  wire to_file = exec_ok & dest_f;
  wire to_w = exec_ok & ~dest_f;

  // ************************************************************
  // state
  // ************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ir_q <= '0;
      data_q <= '0;
      result_q <= '0;
    end else if (ce) begin
      if (ph == fileop_pkg::ph_decode) begin
        ir_q <= insn; // RULE5
      end
      if (ph == fileop_pkg::ph_read) begin
        data_q <= reg_rdata; // RULE5
      end
      if (ph == fileop_pkg::ph_process) begin
        result_q <= proc_val; // RULE5
      end
    end
  end

  // destination write in the last phase
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      w_q <= fileop_pkg::RESET_W;
      z_q <= 1'b0;
      skip_q <= 1'b0;
      wr_q <= 1'b0;
      wdata_q <= '0;
    end else if (ce) begin
      wr_q <= 1'b0;
      if (cycle_end) begin
        if (to_w) begin
          w_q <= result_q; // RULE1 RULE2 RULE3
        end
        if (to_file) begin
          wr_q <= 1'b1;
          wdata_q <= result_q;
        end
        if (upd_z) begin
          z_q <= res_zero; // RULE1 RULE2
        end
        // skip lasts exactly the next instruction cycle
        skip_q <= set_skip; // RULE4 RULE3
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign phase = ph;
  assign insn_taken = ce & (ph == fileop_pkg::ph_decode);
  assign reg_addr = addr;
  assign reg_rd = exec_ok & (ph == fileop_pkg::ph_read);
  assign reg_wr = wr_q;
  assign reg_wdata = wdata_q;
  assign w_reg = w_q;
  assign zero_flag = z_q;
  assign skip_active = skip_q;
  assign unknown_op = ~known & ~skip_q;
endmodule : fileop_exec
`default_nettype wire

/* rtl/fileop_pkg.sv */
// constants for the complement / decrement / skip execution block
// Functional notes
// RULE1 - complement register, zero flag, one cycle
// RULE2 - decrement register, set zero flag
// RULE3 - decrement-and-skip leaves all flags unchanged
// RULE4 - zero result replaces next instruction idle
// RULE5 - four phases: decode, read, process, write
// RULE6 - address bits 6:0, destination bit 7
package fileop_pkg;
  // ************************************************************
  // instruction word layout
  // ************************************************************
  localparam int unsigned INSN_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned OPC_HI = 13;
  localparam int unsigned OPC_LO = 8;
  localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
  localparam logic [5:0] OPC_DECREMENT = 6'h03;
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
  localparam logic [7:0] RESET_W = 8'h00;
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [7:0] ZERO = 8'h00;
  // ************************************************************
  // phases of one instruction cycle
  // ************************************************************
  typedef enum logic [1:0] {
    ph_decode,
    ph_read,
    ph_process,
    ph_write
  } phase_t;
endpackage : fileop_pkg

/* rtl/phase_counter.sv */
// four-phase sequencer of one instruction cycle
`timescale 1ns/1ps
`default_nettype none
module phase_counter (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  output var fileop_pkg::phase_t phase,
  output var logic cycle_end
);
  fileop_pkg::phase_t phase_q;
  fileop_pkg::phase_t phase_d;

  always_comb begin
    case (phase_q)
      fileop_pkg::ph_decode: phase_d = fileop_pkg::ph_read;
      fileop_pkg::ph_read: phase_d = fileop_pkg::ph_process;
      fileop_pkg::ph_process: phase_d = fileop_pkg::ph_write;
      fileop_pkg::ph_write: phase_d = fileop_pkg::ph_decode;
      default: phase_d = fileop_pkg::ph_decode;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= fileop_pkg::ph_decode;
    end else if (ce) begin
      phase_q <= phase_d; // RULE5
    end
  end

  assign phase = phase_q;
  assign cycle_end = (phase_q == fileop_pkg::ph_write);
endmodule : phase_counter
`default_nettype wire

/* verification/fileop_exec_properties.sv */
// assertions for the file-register execution block
`timescale 1ns/1ps
`default_nettype none
module fileop_exec_properties (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [13:0] insn,
  input wire logic [1:0] phase,
  input wire logic insn_taken,
  input wire logic [6:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] w_reg,
  input wire logic zero_flag,
  input wire logic skip_active
);
  logic [7:0] rd_q;
  logic [13:0] ir_q;
  always_ff @(posedge mclk) begin
    if (reg_rd) rd_q <= reg_rdata;
    if (insn_taken) ir_q <= insn;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // opcode and destination bit of an instruction that really executes
  sequence take_s(logic [6:0] od);
    insn_taken && !skip_active && insn[13:7] == od;
  endsequence
  rd_phase_a: assert property (reg_rd |-> phase == 2'h1)
    else $error("file read outside read phase");
  wr_after_a: assert property (reg_wr |->
    phase == 2'h0 && $past(phase) == 2'h3)
    else $error("file write not right after write phase");
  addr_field_a: assert property (reg_rd |-> reg_addr == ir_q[6:0])
    else $error("file address not taken from low bits");
  comp_file_a: assert property (take_s(7'h13) |->
    ##4 reg_wr && reg_wdata == ~rd_q)
    else $error("complement to file wrong");
  comp_w_a: assert property (take_s(7'h12) |->
    ##4 !reg_wr && w_reg == ~rd_q && zero_flag == (rd_q == 8'hff))
    else $error("complement to working register wrong");
  dec_res_a: assert property (take_s(7'h06) |->
    ##4 w_reg == rd_q - 8'h01 && zero_flag == (rd_q == 8'h01))
    else $error("decrement result or zero flag wrong");
  skip_flag_a: assert property (take_s(7'h16) |->
    ##4 zero_flag == $past(zero_flag, 4))
    else $error("decrement-skip changed the zero flag");
  skip_slot_a: assert property (take_s(7'h16) |->
    ##4 skip_active == (rd_q == 8'h01))
    else $error("idle slot not taken on zero result");
endmodule : fileop_exec_properties
bind fileop_exec fileop_exec_properties fileop_exec_properties_inst (.mclk,
  .nrst, .insn, .phase, .insn_taken, .reg_addr, .reg_rd, .reg_rdata, .reg_wr,
  .reg_wdata, .w_reg, .zero_flag, .skip_active);
`default_nettype wire

/* verification/fileop_exec_tb.sv */
// self-checking bench for the file-register execution block
`timescale 1ns/1ps
`default_nettype none
module fileop_exec_tb;
  logic mclk = 0, nrst = 0, ce = 1;
  logic [13:0] insn = 14'h0000;
  logic [7:0] reg_rdata = 8'h00;
  logic [1:0] phase;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, w_reg;
  logic insn_taken, reg_rd, reg_wr, zero_flag, skip_active, unknown_op;
  int n_errors = 0, n_tests = 0;
  fileop_exec fileop_exec_inst (.mclk, .nrst, .ce, .insn, .phase, .insn_taken,
    .reg_addr, .reg_rd, .reg_rdata, .reg_wr, .reg_wdata, .w_reg, .zero_flag,
    .skip_active, .unknown_op);
  initial forever #10 mclk = ~mclk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one instruction cycle, entered and left at a phase-0 falling edge
  task automatic run(input logic [6:0] od, input logic [7:0] v);
    insn = {od, 7'h7f};
    reg_rdata = v;
    repeat (4) @(negedge mclk);
  endtask
  task automatic t_comp;
    run(7'h12, 8'h13);
    chk(w_reg, 8'hec);
    run(7'h13, 8'hff);
    chk(reg_wdata, 8'h00);
    chk({reg_wr, zero_flag, w_reg[5:0]}, 8'hec);
    $display("complement test done");
  endtask
  task automatic t_dec;
    run(7'h07, 8'h01);
    chk({reg_wr, zero_flag, reg_wdata[5:0]}, 8'hc0);
    run(7'h06, 8'h00);
    chk(w_reg, 8'hff);
    chk({zero_flag, reg_addr}, 8'h7f);
    $display("decrement test done");
  endtask
  // frozen enable, then an opcode outside the three
  task automatic t_ce_unknown;
    ce = 0;
    insn = {7'h06, 7'h7f};
    reg_rdata = 8'h05;
    repeat (3) @(negedge mclk);
    chk({6'h00, phase}, 8'h00);
    ce = 1;
    run(7'h06, 8'h05);
    chk(w_reg, 8'h04);
    run(7'h3e, 8'h55);
    chk({unknown_op, w_reg[6:0]}, 8'h84);
    $display("enable and unknown opcode test done");
  endtask
  task automatic t_skip;
    run(7'h16, 8'h01);
    chk({skip_active, zero_flag, w_reg[5:0]}, 8'h80);
    run(7'h06, 8'h05);
    chk({skip_active, w_reg[6:0]}, 8'h00);
    run(7'h17, 8'h03);
    chk({skip_active, reg_wdata[6:0]}, 8'h02);
    $display("skip test done");
  endtask
  task automatic report_and_stop;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    nrst = 1;
    t_comp;
    t_dec;
    t_ce_unknown;
    t_skip;
    report_and_stop;
  end
  initial begin
    #3000;
    n_errors++;
    report_and_stop;
  end
endmodule : fileop_exec_tb
`default_nettype wire
